/* File: dpc_ctrl.sv */
`include "dpc_regs.svh"

module dpc_ctrl #(
	parameter int unsigned BO_DWELL_CYC = `DPC_BO_DWELL_CYC
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic sample_valid,
	input wire dpc_pkg::dpc_sample_t sample,
	output logic gate_drive,
	output dpc_pkg::dpc_status_t status
);

	dpc_pkg::dpc_mode_t mode_r;
	dpc_pkg::dpc_mode_t mode_nxt;
	logic [11:0] fb_r;
	logic [11:0] fb_nxt;
	logic [11:0] line_r;
	logic [11:0] line_nxt;
	logic [11:0] peak_r;
	logic [11:0] peak_nxt;
	logic [11:0] half_max_r;
	logic [11:0] half_max_nxt;
	logic in_zc_r;
	logic in_zc_nxt;
	logic [11:0] demand_r;
	logic [11:0] demand_nxt;
	logic ov_r;
	logic ov_nxt;
	logic loop_r;
	logic loop_nxt;
	logic skip_r;
	logic skip_nxt;
	logic half_edge;
	logic ov_now;
	logic loop_now;
	logic bo_enter;
	logic bo_leave;
	logic signed [13:0] err;
	logic signed [13:0] acc;

	// brownout entry and exit dwell timers
	// entry dwell
	dpc_dwell #(
		.LIMIT(BO_DWELL_CYC)
	) u_bo_enter (
		.mclk(mclk),
		.resetn(resetn),
		.run((peak_r < `DPC_BO_LOWER) && (mode_r != dpc_pkg::dpc_st_brownout)),
		.done(bo_enter)
	);

	dpc_dwell #(
		.LIMIT(BO_DWELL_CYC)
	) u_bo_leave (
		.mclk(mclk),
		.resetn(resetn),
		.run((peak_r > `DPC_BO_UPPER) && (mode_r == dpc_pkg::dpc_st_brownout)),
		.done(bo_leave)
	);

	// fresh-sample protection tests, so the gate drops on the next edge
	// immediate trip
	assign ov_now = sample_valid && (sample.fb > `DPC_OV_TRIP);
	assign loop_now = sample_valid && (sample.fb < sample.line);

	// a half line cycle ends when the line enters the zero-crossing region
	assign half_edge = sample_valid && (sample.line < `DPC_ZC_LEVEL) && !in_zc_r;

	assign err = $signed({2'b00, `DPC_VNOM}) - $signed({2'b00, sample.fb});

	// sample-driven control: sensing, peak tracking, modes and protection
	always_comb
	begin
		fb_nxt = fb_r;
		line_nxt = line_r;
		peak_nxt = peak_r;
		half_max_nxt = half_max_r;
		in_zc_nxt = in_zc_r;
		demand_nxt = demand_r;
		ov_nxt = ov_r;
		loop_nxt = loop_r;
		skip_nxt = skip_r;
		mode_nxt = mode_r;
		acc = 14'sh0;
		if (sample_valid)
		begin
			fb_nxt = sample.fb;
			line_nxt = sample.line;
			in_zc_nxt = sample.line < `DPC_ZC_LEVEL;
			half_max_nxt = (sample.line > half_max_r) ? sample.line : half_max_r;
			// integrating compensation; the demand is taken as delivered power
			// lossless estimate
			acc = $signed({2'b00, demand_r}) + (err >>> 2);
			if (acc < 14'sh0)
				demand_nxt = 12'h000;
			else if (acc > 14'sh0FFF)
				demand_nxt = 12'hFFF;
			else
				demand_nxt = acc[11:0];
		end
		if (half_edge)
		begin
			half_max_nxt = 12'h000;
			if (half_max_r >= peak_r)
				peak_nxt = half_max_r;
			else if ((peak_r - half_max_r) > `DPC_PEAK_DECAY)
				peak_nxt = peak_r - `DPC_PEAK_DECAY;
			else
				peak_nxt = half_max_r;
		end
		if (sample_valid && (sample.fb < (`DPC_OV_THRESHOLD - `DPC_OV_HYST)))
			ov_nxt = 1'b0;
		// a new trip wins over a clear in the same sample
		if (ov_now)
			ov_nxt = 1'b1;
		if (sample_valid && (sample.fb >= sample.line) && (sample.fb > peak_r))
			loop_nxt = 1'b0;
		if (loop_now)
			loop_nxt = 1'b1;
		unique case (mode_r)
			dpc_pkg::dpc_st_startup:
			begin
				if (sample_valid && (sample.fb >= `DPC_STARTUP_EXIT))
					mode_nxt = dpc_pkg::dpc_st_normal;
			end
			dpc_pkg::dpc_st_normal:
			begin
				if (sample_valid && (sample.fb < `DPC_STARTUP_ENTER))
					mode_nxt = dpc_pkg::dpc_st_startup;
				else if (sample_valid && (demand_nxt < `DPC_BURST_ENTER))
					mode_nxt = dpc_pkg::dpc_st_burst;
			end
			dpc_pkg::dpc_st_burst:
			begin
				if (sample_valid && (sample.fb < `DPC_STARTUP_ENTER))
					mode_nxt = dpc_pkg::dpc_st_startup;
				else if (sample_valid && (demand_nxt > `DPC_BURST_EXIT))
					mode_nxt = dpc_pkg::dpc_st_normal;
			end
			dpc_pkg::dpc_st_brownout:
			begin
				if (bo_leave)
					mode_nxt = dpc_pkg::dpc_st_normal;
			end
		endcase
		if (bo_enter)
			mode_nxt = dpc_pkg::dpc_st_brownout;
		if (mode_nxt != dpc_pkg::dpc_st_burst)
			skip_nxt = 1'b0;
		else if (half_edge)
			skip_nxt = !skip_r;
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			mode_r <= dpc_pkg::dpc_st_startup;
			fb_r <= 12'h000;
			line_r <= 12'h000;
			peak_r <= `DPC_PEAK_RST;
			half_max_r <= 12'h000;
			in_zc_r <= 1'b1;
			demand_r <= `DPC_DEMAND_RST;
			ov_r <= 1'b0;
			loop_r <= 1'b0;
			skip_r <= 1'b0;
		end
		else
		begin
			mode_r <= mode_nxt;
			fb_r <= fb_nxt;
			line_r <= line_nxt;
			peak_r <= peak_nxt;
			half_max_r <= half_max_nxt;
			in_zc_r <= in_zc_nxt;
			demand_r <= demand_nxt;
			ov_r <= ov_nxt;
			loop_r <= loop_nxt;
			skip_r <= skip_nxt;
		end
	end

	// switching cycle generator
	logic [11:0] cnt_r;
	logic [11:0] cnt_nxt;
	logic [11:0] period_r;
	logic [11:0] period_nxt;
	logic [11:0] ton_r;
	logic [11:0] ton_nxt;
	logic gate_r;
	logic gate_nxt;
	logic allow;
	logic [15:0] ton_su;
	logic [11:0] ton_calc;
	logic [23:0] toff_calc;
	logic [12:0] period_calc;
	logic [11:0] period_line;
	localparam logic [11:0] MIN_PERIOD = 12'(`DPC_MIN_PERIOD);

	// on-time, off-time and period for the next switching cycle
	always_comb
	begin
		ton_su = 16'hFFFF;
		toff_calc = 24'h0;
		period_line = MIN_PERIOD + ((peak_r > line_r) ? ((peak_r - line_r) >> 1) : 12'h000);
		if (mode_r == dpc_pkg::dpc_st_startup)
		begin
			if (line_r != 12'h000)
				ton_su = `DPC_TON_K / {4'h0, line_r};
			ton_calc = (ton_su > {4'h0, `DPC_TON_MAX}) ? `DPC_TON_MAX : ton_su[11:0];
			// boundary off-time: ton * vin / (vout - vin)
			if (fb_r > line_r)
				toff_calc = ({12'h000, ton_calc} * {12'h000, line_r}) / {12'h000, fb_r - line_r};
			else
				toff_calc = 24'h000FFF;
			if (toff_calc > 24'h000FFF)
				toff_calc = 24'h000FFF;
			period_calc = {1'b0, ton_calc} + {1'b0, toff_calc[11:0]};
		end
		else
		begin
			ton_calc = (demand_r[11:4] > `DPC_TON_MAX) ? `DPC_TON_MAX : {4'h0, demand_r[11:4]};
			period_calc = {1'b0, period_line};
		end
		if (period_calc < {1'b0, MIN_PERIOD})
			period_calc = {1'b0, MIN_PERIOD};
		if (period_calc > 13'h0FFF)
			period_calc = 13'h0FFF;
		period_nxt = period_r;
		ton_nxt = ton_r;
		if (cnt_r >= period_r - 12'h001)
		begin
			cnt_nxt = 12'h000;
			period_nxt = period_calc[11:0];
			ton_nxt = (ton_calc >= period_calc[11:0]) ? period_calc[11:0] - 12'h001 : ton_calc;
		end
		else
			cnt_nxt = cnt_r + 12'h001;
		// protection override
		// skip_nxt, so the gate is already low in the first cycle of a blanked half
		allow = !(ov_now || ov_r || loop_now || loop_r || skip_nxt)
			&& (mode_r != dpc_pkg::dpc_st_brownout) && !bo_enter;
		// pulses start only at cnt 0: a late release must not shorten a pulse
		gate_nxt = allow && (cnt_nxt < ton_nxt) && ((cnt_nxt == 12'h000) || gate_r);
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_r <= 12'h000;
			period_r <= MIN_PERIOD;
			ton_r <= 12'h000;
			gate_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			period_r <= period_nxt;
			ton_r <= ton_nxt;
			gate_r <= gate_nxt;
		end
	end

	// outputs straight from flip-flops, except status.brownout, decoded from mode_r
	assign gate_drive = gate_r;
	assign status.mode = mode_r;
	assign status.ov_guard = ov_r;
	assign status.loop_fault = loop_r;
	assign status.brownout = (mode_r == dpc_pkg::dpc_st_brownout);
	assign status.burst_skip = skip_r;

endmodule

/* File: dpc_regs.svh */
`ifndef DPC_REGS_SVH
`define DPC_REGS_SVH

// sense codes: full feedback reference (400 V link) reads as 1024 counts
`define DPC_ADC_W 12
`define DPC_VNOM_V 400
`define DPC_VNOM 12'h400
// start-up entry below 90 % of nominal, exit at 100 %
`define DPC_STARTUP_ENTER 12'h39A
`define DPC_STARTUP_EXIT 12'h400
// overvoltage trip above 105 % of the reference voltage
`define DPC_OV_TRIP 12'h433
// overvoltage threshold 418 V and its 4 V hysteresis in counts
`define DPC_OV_THRESHOLD 12'h42E
`define DPC_OV_HYST 12'h00A
// tracked line peak decays at most 5 V per half cycle (rounded down)
`define DPC_PEAK_DECAY 12'h00C
// brownout lower threshold 95 V, upper threshold 105 V
`define DPC_BO_LOWER 12'h0F3
`define DPC_BO_UPPER 12'h10D
// line code below this marks the zero-crossing region
`define DPC_ZC_LEVEL 12'h020
// light load: enter burst below 5 % demand, leave above 10 %
`define DPC_BURST_ENTER 12'h0CC
`define DPC_BURST_EXIT 12'h199
// switching timing
`define DPC_MCLK_HZ 10000000
`define DPC_FSW_MAX_HZ 70000
`define DPC_MIN_PERIOD ((`DPC_MCLK_HZ + `DPC_FSW_MAX_HZ - 1) / `DPC_FSW_MAX_HZ)
`define DPC_TON_MAX 12'h0FF
`define DPC_TON_K 16'h2000
// brownout dwell time 56 ms
`define DPC_BO_DWELL_MS 56
`define DPC_BO_DWELL_CYC (`DPC_BO_DWELL_MS * (`DPC_MCLK_HZ / 1000))
// reset values
`define DPC_DEMAND_RST 12'h000
`define DPC_PEAK_RST 12'h000

`endif

/* File: dpc_pkg.sv */
package dpc_pkg;

	// operating modes, gray coded along start-up, normal, burst, brownout
	typedef enum logic [1:0]
	{
		dpc_st_startup = 2'b00,
		dpc_st_normal = 2'b01,
		dpc_st_burst = 2'b11,
		dpc_st_brownout = 2'b10
	} dpc_mode_t;

	// one converter sample of both sense voltages
	typedef struct packed
	{
		logic [11:0] fb;
		logic [11:0] line;
	} dpc_sample_t;

	// controller status seen from outside
	typedef struct packed
	{
		dpc_mode_t mode;
		logic ov_guard;
		logic loop_fault;
		logic brownout;
		logic burst_skip;
	} dpc_status_t;

endpackage

/* File: dpc_dwell.sv */
`include "dpc_regs.svh"

// counts cycles while run is high; done once LIMIT cycles have passed
module dpc_dwell #(
	parameter int unsigned LIMIT = 1
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic run,
	output logic done
);

	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic done_r;
	logic done_nxt;

	// counter saturates at the limit so it never wraps back below it
	always_comb
	begin
		cnt_nxt = cnt_r;
		if (!run)
			cnt_nxt = 32'h0;
		else if (cnt_r < LIMIT)
			cnt_nxt = cnt_r + 32'h1;
		done_nxt = run && (cnt_nxt >= LIMIT);
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_r <= 32'h0;
			done_r <= 1'b0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	assign done = done_r;

endmodule

/* File: dpc_ctrl_chk.sv */
// watches the controller pins; counters give the spacing checks a memory
module dpc_ctrl_chk #(
	parameter int unsigned BO_DWELL_CYC = 50
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic sample_valid,
	input wire dpc_pkg::dpc_sample_t sample,
	input wire logic gate_drive,
	input wire dpc_pkg::dpc_status_t status
);
	timeunit 1ns;
	timeprecision 1ns;
	logic gq_r;
	logic [7:0] gap_r;
	logic [19:0] up_r;
	// saturating: cycles between gate rises, cycles since reset release
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			gq_r <= 1'b0;
			gap_r <= 8'hFF;
			up_r <= '0;
		end
		else
		begin
			gq_r <= gate_drive;
			gap_r <= (gate_drive && !gq_r) ? 8'h01 : gap_r + 8'((gap_r != 8'hFF) ? 1 : 0);
			up_r <= up_r + 20'((up_r < BO_DWELL_CYC) ? 1 : 0);
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	sequence s_ov_trip;
		sample_valid && sample.fb > 12'h433;
	endsequence
	sequence s_loop_trip;
		sample_valid && sample.fb < sample.line;
	endsequence
	a_ov_stop: assert property (s_ov_trip |=> !gate_drive && status.ov_guard)
		else $error("gate not stopped on overvoltage");
	a_loop_stop: assert property (s_loop_trip |=> !gate_drive && status.loop_fault)
		else $error("gate not stopped on loop fault");
	a_prot_gate_low: assert property ((status.ov_guard || status.loop_fault || status.brownout
		|| status.burst_skip) |-> !gate_drive)
		else $error("gate high while blocked");
	a_ov_release: assert property ($fell(status.ov_guard)
		|-> $past(sample_valid && sample.fb < 12'h424))
		else $error("overvoltage cleared above hysteresis");
	a_loop_release: assert property ($fell(status.loop_fault)
		|-> $past(sample_valid && sample.fb >= sample.line))
		else $error("loop fault cleared early");
	a_reset_state: assert property (disable iff (1'b0) !resetn
		|-> status.mode == dpc_pkg::dpc_st_startup && !gate_drive)
		else $error("reset state wrong");
	a_min_period: assert property ($rose(gate_drive) |-> gap_r >= 8'd143)
		else $error("switching too fast");
	a_startup_exit: assert property ($past(status.mode) == dpc_pkg::dpc_st_startup
		&& status.mode == dpc_pkg::dpc_st_normal
		|-> $past(sample_valid && sample.fb >= 12'h400))
		else $error("left start-up below nominal");
	a_startup_reentry: assert property ($past(status.mode) == dpc_pkg::dpc_st_normal
		&& status.mode == dpc_pkg::dpc_st_startup
		|-> $past(sample_valid && sample.fb < 12'h39A))
		else $error("start-up re-entered above 90 percent");
	a_bo_dwell: assert property ($rose(status.brownout) |-> up_r >= BO_DWELL_CYC)
		else $error("brownout before dwell");
endmodule

/* File: dpc_plant.sv */
// sense network: one sample pair every 8 cycles, line a 32-step rectified triangle;
// the link level is held by the bench so faults can be placed at will
module dpc_plant (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [11:0] fb_set,
	input wire logic [11:0] line_pk,
	output logic sample_valid,
	output dpc_pkg::dpc_sample_t sample
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] div_r;
	logic [4:0] ph_r;
	function automatic logic [11:0] tri_line(input logic [4:0] ph, input logic [11:0] pk);
		logic [16:0] p;
		p = (ph[4] ? 17'(6'd32 - ph) : 17'(ph)) * pk;
		return p[15:4];
	endfunction
	// phase 0 reads zero, which closes each half line
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			div_r <= '0;
			ph_r <= '0;
			sample_valid <= 1'b0;
			sample <= '0;
		end
		else
		begin
			div_r <= div_r + 3'h1;
			sample_valid <= div_r == 3'h7;
			if (div_r == 3'h7)
			begin
				ph_r <= ph_r + 5'h01;
				sample.fb <= fb_set;
				sample.line <= tri_line(ph_r, line_pk);
			end
		end
	end
endmodule

/* File: dpc_ctrl_tb.sv */
module dpc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// short dwell keeps the brownout runs brief
	// but longer than a half line, else the zero peak after reset trips brownout
	localparam int unsigned DWELL = 600;
	logic mclk = 1'b0;
	logic resetn = 1'b1;
	logic [11:0] fb_set = 12'h380;
	logic [11:0] line_pk = 12'h200;
	logic sample_valid;
	dpc_pkg::dpc_sample_t sample;
	logic gate_drive;
	dpc_pkg::dpc_status_t status;
	int fails = 0;
	int n_tests = 0;
	int cyc = 0;
	int t0 = 0;
	logic [31:0] lfsr = 32'hBC54;
	logic exp_ov = 1'b0;
	logic saw_skip = 1'b0;
	logic saw_gate = 1'b0;
	dpc_plant i_dpc_plant (.mclk(mclk), .resetn(resetn), .fb_set(fb_set), .line_pk(line_pk),
		.sample_valid(sample_valid), .sample(sample));
	dpc_ctrl #(.BO_DWELL_CYC(DWELL)) i_dpc_ctrl (.mclk(mclk), .resetn(resetn),
		.sample_valid(sample_valid), .sample(sample), .gate_drive(gate_drive), .status(status));
	initial
	begin
		forever #50 mclk = ~mclk;
	end
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	// overvoltage latch: trips above 105 %, clears below threshold minus hysteresis
	function automatic logic ov_next(input logic cur, input logic [11:0] fb);
		return (fb > 12'h433) ? 1'b1 : ((fb < 12'h424) ? 1'b0 : cur);
	endfunction
	task automatic print_verdict();
		$display("tests %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk_bit(input logic got, input logic exp, input string msg);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	task automatic chk_mode(input dpc_pkg::dpc_mode_t exp, input string msg);
		n_tests++;
		if (status.mode !== exp)
		begin
			fails++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	task automatic wait_mode(input dpc_pkg::dpc_mode_t m, input int n);
		for (int i = 0; i < n && status.mode !== m; i++)
			@(negedge mclk);
	endtask
	// two samples so the newest one surely carries the value just set
	task automatic samples(input int n);
		repeat (n) @(posedge mclk iff sample_valid === 1'b1);
		@(negedge mclk);
	endtask
	// hang guard, also records burst blanking and switching
	always @(negedge mclk)
	begin
		cyc++;
		if (status.burst_skip === 1'b1)
			saw_skip = 1'b1;
		if (gate_drive === 1'b1)
			saw_gate = 1'b1;
		if (cyc == 60000)
		begin
			fails++;
			$display("unexpected at %0t: run too long", $time);
			print_verdict();
		end
	end
	initial
	begin
		// a true falling edge, so the flops clear before the first clock
		#1 resetn = 1'b0;
		repeat (10) @(negedge mclk);
		resetn = 1'b1;
		chk_bit(gate_drive, 1'b0, "gate after reset");
		chk_mode(dpc_pkg::dpc_st_startup, "mode after reset");
		repeat (400) @(negedge mclk);
		chk_mode(dpc_pkg::dpc_st_startup, "left start-up low");
		chk_bit(saw_gate, 1'b1, "no switching in start-up");
		fb_set = 12'h400;
		wait_mode(dpc_pkg::dpc_st_normal, 200);
		chk_mode(dpc_pkg::dpc_st_normal, "no normal at nominal");
		saw_gate = 1'b0;
		samples(60);
		chk_bit(saw_gate, 1'b1, "no switching in normal");
		fb_set = 12'h39A;
		samples(4);
		chk_mode(dpc_pkg::dpc_st_normal, "start-up at 90 percent");
		fb_set = 12'h399;
		samples(2);
		chk_mode(dpc_pkg::dpc_st_startup, "no start-up below 90");
		fb_set = 12'h434;
		samples(2);
		chk_bit(status.ov_guard, 1'b1, "no overvoltage");
		chk_bit(gate_drive, 1'b0, "gate in overvoltage");
		fb_set = 12'h424;
		samples(2);
		chk_bit(status.ov_guard, 1'b1, "overvoltage left early");
		fb_set = 12'h423;
		samples(2);
		chk_bit(status.ov_guard, 1'b0, "overvoltage stuck");
		fb_set = 12'h100;
		samples(20);
		chk_bit(status.loop_fault, 1'b1, "no loop fault");
		chk_bit(gate_drive, 1'b0, "gate in loop fault");
		fb_set = 12'h400;
		samples(40);
		chk_bit(status.loop_fault, 1'b0, "loop fault stuck");
		for (int i = 0; i < 40; i++)
		begin
			lfsr = lfsr_next(lfsr);
			fb_set = 12'h3F0 + 12'(lfsr[6:0]);
			samples(2);
			exp_ov = ov_next(exp_ov, fb_set);
			chk_bit(status.ov_guard, exp_ov, "random overvoltage");
		end
		fb_set = 12'h400;
		wait_mode(dpc_pkg::dpc_st_normal, 400);
		line_pk = 12'h0C0;
		t0 = cyc;
		wait_mode(dpc_pkg::dpc_st_brownout, 20000);
		chk_mode(dpc_pkg::dpc_st_brownout, "no brownout");
		chk_bit(cyc - t0 >= 22 * 256, 1'b1, "peak fell too fast");
		chk_bit(gate_drive, 1'b0, "gate in brownout");
		line_pk = 12'h200;
		t0 = cyc;
		wait_mode(dpc_pkg::dpc_st_normal, 2000);
		chk_mode(dpc_pkg::dpc_st_normal, "no recovery to normal");
		chk_bit(cyc - t0 >= DWELL, 1'b1, "recovered before dwell");
		fb_set = 12'h41F;
		wait_mode(dpc_pkg::dpc_st_burst, 20000);
		chk_mode(dpc_pkg::dpc_st_burst, "no burst at light load");
		saw_skip = 1'b0;
		repeat (1024) @(negedge mclk);
		chk_bit(saw_skip, 1'b1, "no blanked half line");
		print_verdict();
	end
endmodule
bind dpc_ctrl dpc_ctrl_chk #(.BO_DWELL_CYC(BO_DWELL_CYC)) i_dpc_ctrl_chk (.mclk(mclk),
	.resetn(resetn), .sample_valid(sample_valid), .sample(sample), .gate_drive(gate_drive),
	.status(status));
